// File: asp_pkg.sv
package asp_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int SAMPLE_W = 16;
  localparam int BYTE_W   = 8;
  localparam int CDIV_W   = 16;
  localparam int CNT_W    = 5;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LOW    = 8'h08;
  localparam logic [7:0] OFS_HIGH   = 8'h0c;
  localparam logic [7:0] OFS_CDIV   = 8'h10;

  // ==========================================================================
  // Status bit positions
  // ==========================================================================
  localparam int ST_RXC  = 0;
  localparam int ST_TXC  = 1;
  localparam int ST_UNF  = 2;
  localparam int ST_OVF  = 3;
  localparam int ST_TRANSMIT_CHANNEL_SIDE = 4;
  localparam int ST_RECEIVE_CHANNEL_SIDE = 5;

  // ==========================================================================
  // Reset values and limits
  // ==========================================================================
  localparam logic [10:0]       CONFIG_RESET = 11'h000;
  localparam logic [CDIV_W-1:0] CDIV_RESET   = 16'h0010;
  localparam logic [CNT_W-1:0]  FULL_COUNT   = 5'h10;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic {
    SIDE_LEFT  = 1'b0,
    SIDE_RIGHT = 1'b1
  } asp_side_type;

  typedef struct packed {
    logic [4:0] word_len_m1;
    logic       receive_single_channel;
    logic       transmit_single_channel;
    logic       receive_irq_enable;
    logic       transmit_irq_enable;
    logic       master;
    logic       port_on;
  } asp_cfg_type;

  typedef struct packed {
    logic sck;
    logic ws;
    logic sd;
  } asp_link_in_type;

  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic ws;
    logic ws_oe_n;
    logic sd;
  } asp_link_out_type;

endpackage : asp_pkg

// File: asp_port.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps

// Operation
// - Master drives bit clock and word select; slave takes both as inputs.
// - One data bit per bit-clock cycle, most significant bit first.
// - Word select low marks left, high marks right; its period sets word length.
// - Word select changes with each word's last bit, one bit before the next word's first bit.
// - Transmit sample inverted before shifting; received bits inverted before buffering.
// - Serial transfer runs only while port_on is set.
// - Refilling the empty transmit buffer sets transmit_complete_flag and the enabled interrupt.
// - Writing sample_high_byte clears transmit_complete_flag.
// - Full receive buffer copies to data pair, sets receive_complete_flag.
// - Reading sample_high_byte clears receive_complete_flag.
// - Software setting a complete flag also raises the enabled interrupt.
// - Both requests merge on one shared interrupt line; handler checks flags.
// - DMA triggers pulse on complete events, unmasked by interrupt enables.
// - Shifter needing data from an empty buffer resends stale data, flags underflow.
// - Word arriving into a full receive buffer overwrites it, flags overflow.
// - High byte write ends a sample write and releases the pair.
// - Stereo transmit shows which channel the next written sample feeds.
// - Stereo receive shows which channel the held sample came from.
// - Mono uses one sample for both channels.
// - Configuration bit master selects link master when one, slave when zero.
// - Slave transmit sends zeros once sixteen buffered bits are used up.
module asp_port
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Audio link pins
  input  wire asp_pkg::asp_link_in_type  link_in,
  output asp_pkg::asp_link_out_type      link_out,
  // Shared interrupt and DMA triggers
  output logic                           irq_request,
  output logic                           receive_dma_trigger,
  output logic                           transmit_dma_trigger
);
  import asp_pkg::*;

  // The decoder always looks at eight address bits.
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_addr_w_check
    $error("asp_port: ADDR_W must lie between 8 and 32.");
  end

  // ==========================================================================
  // Registers and state
  // ==========================================================================
  asp_cfg_type             cfg;
  logic [CDIV_W-1:0]       cdiv;
  logic [CDIV_W-1:0]       div_cnt;
  logic                    rxc_flag;
  logic                    txc_flag;
  logic                    unf_flag;
  logic                    ovf_flag;
  logic [BYTE_W-1:0]       wr_low;
  logic [BYTE_W-1:0]       wr_high;
  logic                    sample_pending;
  logic [SAMPLE_W-1:0]     tx_buf;
  logic                    tx_full;
  logic [SAMPLE_W-1:0]     tx_cur;
  logic [SAMPLE_W-1:0]     tx_shift;
  asp_side_type            tx_side;
  logic [SAMPLE_W-1:0]     rx_shift;
  logic [CNT_W-1:0]        rx_cnt;
  logic [SAMPLE_W-1:0]     rx_data;
  logic                    rx_full;
  asp_side_type            rx_side;
  asp_link_in_type         sync1;
  asp_link_in_type         sync2;
  logic                    sck_int;
  logic                    ws_int;
  logic [CNT_W-1:0]        bit_idx;
  logic                    sck_d;
  asp_side_type            ws_prev;
  asp_side_type            new_side;
  logic                    start_pend;
  logic                    sck_pin;
  logic                    sck_oe_n_pin;
  logic                    ws_pin;
  logic                    ws_oe_n_pin;
  logic                    sd_pin;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  addr8;
  logic        mapped;
  logic [31:0] next_prdata;

  assign access = psel & penable & pready;
  assign wr_en  = access & pwrite;
  assign rd_en  = access & ~pwrite;
  assign addr8  = paddr[7:0];
  assign mapped = (addr8 == OFS_CONFIG) || (addr8 == OFS_STATUS) || (addr8 == OFS_LOW)
               || (addr8 == OFS_HIGH) || (addr8 == OFS_CDIV);

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (addr8)
      OFS_CONFIG: next_prdata[10:0] = cfg;
      OFS_STATUS:
      begin
        next_prdata[ST_RXC]  = rxc_flag;
        next_prdata[ST_TXC]  = txc_flag;
        next_prdata[ST_UNF]  = unf_flag;
        next_prdata[ST_OVF]  = ovf_flag;
        next_prdata[ST_TRANSMIT_CHANNEL_SIDE] = tx_side;
        next_prdata[ST_RECEIVE_CHANNEL_SIDE] = rx_side;
      end
      OFS_LOW:    next_prdata[BYTE_W-1:0] = rx_data[BYTE_W-1:0];
      OFS_HIGH:   next_prdata[BYTE_W-1:0] = rx_data[SAMPLE_W-1:BYTE_W];
      OFS_CDIV:   next_prdata[CDIV_W-1:0] = cdiv;
      default:    next_prdata = 32'h0000_0000;
    endcase
  end

  // One wait-free access phase: the answer is ready in the first access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable)
        prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg  <= CONFIG_RESET;
      cdiv <= CDIV_RESET;
    end
    else if (wr_en && addr8 == OFS_CONFIG)
      cfg <= pwdata[10:0];
    else if (wr_en && addr8 == OFS_CDIV)
      cdiv <= pwdata[CDIV_W-1:0];
  end

  // ==========================================================================
  // Pin synchronisers and edge detection
  // ==========================================================================
  logic sck_lvl;
  logic ws_lvl;
  logic rise_ev;
  logic fall_ev;
  logic boundary;
  logic sck_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= link_in;
      sync2 <= sync1;
    end
  end

  assign sck_lvl  = cfg.master ? sck_int : sync2.sck;
  assign ws_lvl   = cfg.master ? ws_int : sync2.ws;
  assign sck_rise = sck_lvl & ~sck_d;
  assign rise_ev  = cfg.port_on & sck_rise;
  assign fall_ev  = cfg.port_on & ~sck_lvl & sck_d;
  // word select edge ends a word
  assign boundary = rise_ev & (ws_lvl != ws_prev);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_d      <= 1'b0;
      ws_prev    <= SIDE_LEFT;
      new_side   <= SIDE_LEFT;
      start_pend <= 1'b0;
    end
    else
    begin
      sck_d <= sck_lvl;
      // The select history follows the line even while the port is off, so the
      // lead edge of the first frame after enabling is not lost.
      if (sck_rise)
        ws_prev <= asp_side_type'(ws_lvl);
      if (boundary)
      begin
        new_side   <= asp_side_type'(ws_lvl);
        start_pend <= 1'b1;
      end
      else if (fall_ev)
        start_pend <= 1'b0;
    end
  end

  // ==========================================================================
  // Master clock and word select generation
  // ==========================================================================
  logic [CNT_W-1:0] next_bit_idx;

  assign next_bit_idx = (bit_idx == cfg.word_len_m1) ? '0 : bit_idx + 5'h01;

  // master role generates the link timing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= '0;
      sck_int <= 1'b0;
      ws_int  <= 1'b0;
      bit_idx <= '0;
    end
    else if (!(cfg.master && cfg.port_on))
    begin
      div_cnt <= '0;
      sck_int <= 1'b0;
      ws_int  <= 1'b0;
      bit_idx <= '0;
    end
    else if (cdiv == '0 || div_cnt >= cdiv - 16'h0001)
    begin
      div_cnt <= '0;
      sck_int <= ~sck_int;
      if (sck_int)
      begin
        bit_idx <= next_bit_idx;
        if (next_bit_idx == cfg.word_len_m1)
          ws_int <= ~ws_int;
      end
    end
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // ==========================================================================
  // Transmit path
  // ==========================================================================
  logic refill;
  logic fetch;
  logic repeat_word;
  logic unf_ev;
  logic dath_wr;

  assign dath_wr     = wr_en & (addr8 == OFS_HIGH);
  assign refill      = cfg.port_on & ~tx_full & sample_pending;
  // mono repeats the left word on the right
  assign repeat_word = cfg.transmit_single_channel & (new_side == SIDE_RIGHT);
  assign fetch       = fall_ev & start_pend & ~repeat_word;
  assign unf_ev      = fetch & ~tx_full;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_low         <= '0;
      wr_high        <= '0;
      sample_pending <= 1'b0;
    end
    else
    begin
      if (wr_en && addr8 == OFS_LOW)
        wr_low <= pwdata[BYTE_W-1:0];
      if (dath_wr)
        wr_high <= pwdata[BYTE_W-1:0];
      // high byte write releases the pair
      if (dath_wr)
        sample_pending <= 1'b1;
      else if (refill)
        sample_pending <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buf  <= '0;
      tx_full <= 1'b0;
      tx_side <= SIDE_LEFT;
    end
    else if (refill)
    begin
      tx_buf  <= {wr_high, wr_low};
      tx_full <= 1'b1;
      tx_side <= cfg.transmit_single_channel ? SIDE_LEFT : asp_side_type'(~tx_side);
    end
    else if (fetch)
      tx_full <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_cur       <= '0;
      tx_shift     <= '0;
      sd_pin       <= 1'b0;
    end
    else if (fall_ev)
    begin
      if (start_pend)
      begin
        tx_cur      <= repeat_word ? tx_cur : tx_buf;
        tx_shift    <= {~(repeat_word ? tx_cur : tx_buf)} << 1;
        sd_pin      <= ~(repeat_word ? tx_cur[SAMPLE_W-1] : tx_buf[SAMPLE_W-1]);
      end
      else
      begin
        sd_pin      <= tx_shift[SAMPLE_W-1];
        tx_shift    <= {tx_shift[SAMPLE_W-2:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // Receive path
  // ==========================================================================
  logic [SAMPLE_W-1:0] next_rx_shift;
  logic [CNT_W-1:0]    next_rx_cnt;
  logic [SAMPLE_W-1:0] rx_word;
  logic                rx_done;
  logic                ovf_ev;
  logic                dath_rd;

  always_comb
  begin
    next_rx_shift = rx_shift;
    next_rx_cnt   = rx_cnt;
    if (rx_cnt < FULL_COUNT)
    begin
      next_rx_shift = {rx_shift[SAMPLE_W-2:0], ~sync2.sd};
      next_rx_cnt   = rx_cnt + 5'h01;
    end
    rx_word = next_rx_shift << (FULL_COUNT - next_rx_cnt);
  end

  assign dath_rd = rd_en & (addr8 == OFS_HIGH);
  assign rx_done = boundary & ~(cfg.receive_single_channel & (ws_prev == SIDE_RIGHT));
  assign ovf_ev  = rx_done & rx_full;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_shift <= '0;
      rx_cnt   <= '0;
    end
    else if (boundary)
    begin
      rx_shift <= '0;
      rx_cnt   <= '0;
    end
    else if (rise_ev)
    begin
      rx_shift <= next_rx_shift;
      rx_cnt   <= next_rx_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_data <= '0;
      rx_full <= 1'b0;
      rx_side <= SIDE_LEFT;
    end
    else if (rx_done)
    begin
      rx_data <= rx_word;
      rx_full <= 1'b1;
      rx_side <= ws_prev;
    end
    // high read ends the sample read
    else if (dath_rd)
      rx_full <= 1'b0;
  end

  // ==========================================================================
  // Status flags, interrupt and DMA triggers
  // ==========================================================================
  logic st_wr;

  assign st_wr = wr_en & (addr8 == OFS_STATUS);

  // Hardware events win over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxc_flag <= 1'b0;
      txc_flag <= 1'b0;
      unf_flag <= 1'b0;
      ovf_flag <= 1'b0;
    end
    else
    begin
      if (rx_done)
        rxc_flag <= 1'b1;
      else if (dath_rd)
        rxc_flag <= 1'b0;
      else if (st_wr)
        rxc_flag <= pwdata[ST_RXC];
      if (refill)
        txc_flag <= 1'b1;
      else if (dath_wr)
        txc_flag <= 1'b0;
      else if (st_wr)
        txc_flag <= pwdata[ST_TXC];
      if (unf_ev)
        unf_flag <= 1'b1;
      else if (st_wr)
        unf_flag <= pwdata[ST_UNF];
      if (ovf_ev)
        ovf_flag <= 1'b1;
      else if (st_wr)
        ovf_flag <= pwdata[ST_OVF];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_request          <= 1'b0;
      receive_dma_trigger  <= 1'b0;
      transmit_dma_trigger <= 1'b0;
    end
    else
    begin
      irq_request          <= (rxc_flag & cfg.receive_irq_enable)
                            | (txc_flag & cfg.transmit_irq_enable);
      receive_dma_trigger  <= rx_done;
      transmit_dma_trigger <= refill;
    end
  end

  // ==========================================================================
  // Link pin drive
  // ==========================================================================
  // drive clock and word select only as master
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_pin      <= 1'b0;
      ws_pin       <= 1'b0;
      sck_oe_n_pin <= 1'b1;
      ws_oe_n_pin  <= 1'b1;
    end
    else
    begin
      sck_pin      <= sck_int;
      ws_pin       <= ws_int;
      sck_oe_n_pin <= ~(cfg.master & cfg.port_on);
      ws_oe_n_pin  <= ~(cfg.master & cfg.port_on);
    end
  end

  // Each pin field has its own flip-flop, so the bundle has a single driver.
  assign link_out = '{sck: sck_pin, sck_oe_n: sck_oe_n_pin, ws: ws_pin,
                      ws_oe_n: ws_oe_n_pin, sd: sd_pin};

endmodule : asp_port

// File: asp_port_properties.sv
`timescale 1ns/1ps

// ==========================================================================
// Port checker
// ==========================================================================
module asp_port_checker
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // Register bus
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [ADDR_W-1:0]         paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Link and events
  input wire asp_pkg::asp_link_in_type  link_in,
  input wire asp_pkg::asp_link_out_type link_out,
  input wire logic                      irq_request,
  input wire logic                      receive_dma_trigger,
  input wire logic                      transmit_dma_trigger
);
  import asp_pkg::*;
  logic        take;
  logic        master_on;
  logic [10:0] cfg;

  assign take = psel && penable && pready;
  assign master_on = cfg[1] && cfg[0];

  // Shadow of the configuration word, since the checker cannot see inside.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg <= CONFIG_RESET;
    else if (take && pwrite && paddr[7:0] == OFS_CONFIG)
      cfg <= pwdata[10:0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  bus_answer_a:
    assert property (psel && !penable |=> pready) else $error("no ready in access cycle");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready held too long");
  unmapped_err_a:
    assert property (take && paddr[7:0] > OFS_CDIV |-> pslverr) else $error("no error");
  tx_dma_pulse_a:
    assert property (transmit_dma_trigger |=> !transmit_dma_trigger) else $error("tx pulse");
  rx_dma_pulse_a:
    assert property (receive_dma_trigger |=> !receive_dma_trigger) else $error("rx pulse");
  soft_irq_a:
    assert property (take && pwrite && paddr[7:0] == OFS_STATUS && pwdata[ST_RXC] && cfg[3]
      |-> ##[1:2] irq_request) else $error("software flag raised no interrupt");
  slave_release_a:
    assert property (!master_on [*3] |-> link_out.sck_oe_n && link_out.ws_oe_n)
      else $error("link lines driven as slave");
  master_drive_a:
    assert property ($rose(master_on) |-> ##[0:2] !link_out.sck_oe_n)
      else $error("master did not drive the clock");
  ws_on_fall_a:
    assert property (!link_out.ws_oe_n && !$past(link_out.ws_oe_n) && $changed(link_out.ws)
      |-> !link_out.sck) else $error("select moved with clock high");
  sd_on_fall_a:
    assert property ($changed(link_out.sd) |-> !link_in.sck) else $error("data moved late");

  rx_event_c: cover property (receive_dma_trigger);
  tx_event_c: cover property (transmit_dma_trigger);
  refused_c: cover property (take && pslverr);
endmodule : asp_port_checker

bind asp_port asp_port_checker #(.ADDR_W(ADDR_W)) i_asp_port_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_in(link_in), .link_out(link_out), .irq_request(irq_request),
  .receive_dma_trigger(receive_dma_trigger), .transmit_dma_trigger(transmit_dma_trigger)
);

// File: asp_codec_model.sv
`timescale 1ns/1ps

// ==========================================================================
// Codec acting as link master
// ==========================================================================
module asp_codec_model
(
  // Lines driven toward the port
  output asp_pkg::asp_link_in_type       drive,
  // Lines driven by the port
  input  wire asp_pkg::asp_link_out_type link_out
);
  import asp_pkg::*;
  logic [15:0] tx_word [0:2];
  logic [15:0] heard   [0:2];

  initial drive = '{1'b0, 1'b1, 1'b0};

  // clock, select, order
  // The clock stands still between frames, so each frame opens with one lead bit.
  task automatic play(input int n);
    #1.7;
    drive.ws = 1'b0;
    drive.sd = ~drive.sd;
    #80 drive.sck = 1'b1;
    #80 drive.sck = 1'b0;
    for (int i = 0; i < n; i++)
      for (int b = 15; b >= 0; b--)
      begin
        drive.sd = tx_word[i][b];
        if (b == 0)
          drive.ws = ~drive.ws;
        #80 drive.sck = 1'b1;
        heard[i][b] = link_out.sd;
        #80 drive.sck = 1'b0;
      end
    drive.sd = ~drive.sd;
  endtask : play
endmodule : asp_codec_model

// File: audio_serial_port_test.sv
`timescale 1ns/1ps

// ==========================================================================
// Bench
// ==========================================================================
module audio_serial_port_test;
  import asp_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             pready, pslverr, rderr, irq_request;
  logic             receive_dma_trigger, transmit_dma_trigger, ws0, sck0;
  asp_link_in_type  link_in, drive;
  asp_link_out_type link_out;
  int               err_count, total_checks, tx_pulses, edges, seen;

  asp_port i_asp_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_in(link_in), .link_out(link_out), .irq_request(irq_request),
    .receive_dma_trigger(receive_dma_trigger), .transmit_dma_trigger(transmit_dma_trigger)
  );
  asp_codec_model i_asp_codec_model (.drive(drive), .link_out(link_out));

  // Whoever has its enable low owns the shared clock and select wires.
  assign link_in.sck = link_out.sck_oe_n ? drive.sck : link_out.sck;
  assign link_in.ws  = link_out.ws_oe_n ? drive.ws : link_out.ws;
  assign link_in.sd  = drive.sd;

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (transmit_dma_trigger === 1'b1)
      tx_pulses++;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    rderr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial
  begin
    #200000;
    err_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    summarize();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CONFIG, 32'h0);
    check("config", {21'h0, CONFIG_RESET}, rd);
    apb(1'b0, OFS_CDIV, 32'h0);
    check("divider", {16'h0, CDIV_RESET}, rd);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h1, {31'h0, rderr});
    i_asp_codec_model.tx_word = '{16'h1234, 16'hc0de, 16'h5a3c};
    i_asp_codec_model.play(1);
    @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("status off", 32'h0, rd);
    apb(1'b1, OFS_CONFIG, 32'h0d);
    apb(1'b1, OFS_LOW, 32'h3c);
    apb(1'b1, OFS_HIGH, 32'h96);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("refill status", 32'h12, rd);
    check("tx irq", 32'h1, {31'h0, irq_request});
    check("tx dma", 32'h1, tx_pulses);
    apb(1'b1, OFS_LOW, 32'h81);
    apb(1'b1, OFS_HIGH, 32'h7e);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("tx flag cleared", 32'h10, rd);
    i_asp_codec_model.play(3);
    @(posedge pclk);
    check("left word", 32'h69c3, {16'h0, i_asp_codec_model.heard[0]});
    check("right word", 32'h817e, {16'h0, i_asp_codec_model.heard[1]});
    apb(1'b0, OFS_STATUS, 32'h0);
    check("frame status", 32'h0f, rd);
    apb(1'b0, OFS_LOW, 32'h0);
    check("low byte", 32'hc3, rd);
    apb(1'b0, OFS_HIGH, 32'h0);
    check("high byte", 32'ha5, rd);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("rx flag cleared", 32'h0e, rd);
    check("tx dma count", 32'h2, tx_pulses);
    apb(1'b1, OFS_STATUS, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h09);
    apb(1'b1, OFS_STATUS, 32'h1);
    @(posedge pclk);
    check("software irq", 32'h1, {31'h0, irq_request});
    apb(1'b1, OFS_CONFIG, 32'h21);
    @(posedge pclk);
    check("irq masked", 32'h0, {31'h0, irq_request});
    apb(1'b1, OFS_STATUS, 32'h0);
    i_asp_codec_model.tx_word[0] = 16'h1e2d;
    i_asp_codec_model.tx_word[1] = 16'hffff;
    i_asp_codec_model.play(2);
    @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("mono status", 32'h05, rd);
    apb(1'b0, OFS_HIGH, 32'h0);
    check("mono sample", 32'he1, rd);
    apb(1'b1, OFS_CONFIG, 32'h3c3);
    @(posedge pclk);
    check("master", 32'h0, {30'h0, link_out.sck_oe_n, link_out.ws_oe_n});
    ws0 = link_out.ws;
    sck0 = link_out.sck;
    repeat (3000)
    begin
      @(posedge pclk);
      if (link_out.sck === 1'b1 && sck0 === 1'b0 && seen == 1)
        edges++;
      if (link_out.ws !== ws0)
        seen++;
      ws0 = link_out.ws;
      sck0 = link_out.sck;
    end
    check("word period", 32'd16, edges);
    apb(1'b1, OFS_CONFIG, 32'h0);
    @(posedge pclk);
    check("slave", 32'h3, {30'h0, link_out.sck_oe_n, link_out.ws_oe_n});
    summarize();
  end
endmodule : audio_serial_port_test
